// *** verilog/tcop_polarity.v ***
// channel output polarity register with write protection and fault safe levels
// assumes one AHB-Lite master whose hready is fed from this slave's hreadyout,
// channel active states from logic on hclk and a fault request from a pin
//
// How it works
// - polarity register at 0x70, bit n steers channel n.
// - each polarity bit sets the sense of its channel pin.
// - polarity 0 means active high, 1 means active low.
// - polarity writes take effect only while write protect disable is 1.
// - enabled fault forces every channel pin to its polarity bit level.
// - bits 31 to 8 read zero and do nothing.
// - protect enable reads inverse of disable; writing 1 re-arms, 0 ignored.
`timescale 1ns/1ps
`include "tcop_regs.vh"
module tcop_polarity (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [7:0]  chan_active,
  input  wire        fault_in,
  output reg  [7:0]  chan_pin
);

  localparam CH_N   = `TCOP_NCH;
  localparam ADDR_W = `TCOP_ADDR_W;

  // register map (byte offsets, one word each)
  //   0x70 channel polarity, bits 7:0
  //   0x54 mode: bit 2 protect disable (set only), bit 0 fault enable
  //   0x74 fault status: bit 6 protect enable, the inverse of protect disable
  //   0x78 bit 0 high while a fault forces the pins

  // address phase capture
  reg                addr_wr_q;
  reg  [ADDR_W-1:0]  addr_q;
  wire [ADDR_W-1:0]  addr_d;
  wire               acc;
  wire               rd_acc;
  wire               wr_acc;

  // decoded data phase writes
  wire               wr_polarity;
  wire               wr_mode;
  wire               wr_fltstat;

  // software visible state
  reg  [CH_N-1:0]    channel_output_polarity_q;
  reg  [CH_N-1:0]    channel_output_polarity_d;
  reg                write_protect_disable_q;
  reg                write_protect_disable_d;
  reg                fault_enable_q;
  reg                fault_enable_d;
  wire               write_protect_enable_d;

  // fault pin synchroniser
  reg                flt_meta_q;
  reg                flt_sync_q;
  wire               fault_act;

  // read path and pins
  reg  [31:0]        rdata_d;
  wire [CH_N-1:0]    pin_d;

  // no wait states and never an error response
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;

  // a transfer is taken only when the bus is ready and htrans is NONSEQ or SEQ
  assign acc    = hsel & hready & htrans[1];
  assign rd_acc = acc & ~hwrite;
  assign wr_acc = acc & hwrite;

  // word aligned, only the low address bits select a register
  assign addr_d = {haddr[ADDR_W-1:2], 2'h0};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_wr_q <= 1'h0;
      addr_q    <= 12'h000;
    end else begin
      addr_wr_q <= wr_acc;
      addr_q    <= addr_d;
    end
  end

  assign wr_polarity = addr_wr_q & (addr_q == `TCOP_CHANPOL_OFF);
  assign wr_mode     = addr_wr_q & (addr_q == `TCOP_MODE_OFF);
  assign wr_fltstat  = addr_wr_q & (addr_q == `TCOP_FLTSTAT_OFF);

  // next register values; the read path uses them so that a read whose
  // address phase meets a write's data phase returns the new contents
  always @* begin
    channel_output_polarity_d = channel_output_polarity_q;
    if (wr_polarity && write_protect_disable_q) begin
      channel_output_polarity_d = hwdata[CH_N-1:0];
    end
  end

  always @* begin
    write_protect_disable_d = write_protect_disable_q;
    // re-arm wins over a disable request in the same cycle
    if (wr_fltstat && hwdata[`TCOP_FLTSTAT_PROTEN_BIT]) begin
      write_protect_disable_d = 1'h0;
    end else if (wr_mode && hwdata[`TCOP_MODE_PROTDIS_BIT]) begin
      write_protect_disable_d = 1'h1;
    end
  end

  always @* begin
    fault_enable_d = fault_enable_q;
    // fault control stays locked while protection is armed
    if (wr_mode && write_protect_disable_q) begin
      fault_enable_d = hwdata[`TCOP_MODE_FAULTEN_BIT];
    end
  end

  assign write_protect_enable_d = ~write_protect_disable_d;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_output_polarity_q <= `TCOP_CHANPOL_RST;
    end else begin
      channel_output_polarity_q <= channel_output_polarity_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_protect_disable_q <= 1'h0;
    end else begin
      write_protect_disable_q <= write_protect_disable_d;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_enable_q <= 1'h0;
    end else begin
      fault_enable_q <= fault_enable_d;
    end
  end

  // fault_in is asynchronous: two flops before anything reads it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_meta_q <= 1'h0;
      flt_sync_q <= 1'h0;
    end else begin
      flt_meta_q <= fault_in;
      flt_sync_q <= flt_meta_q;
    end
  end

  assign fault_act = fault_enable_q & flt_sync_q;

  // reserved and unmapped bits stay zero
  always @* begin
    rdata_d = 32'h00000000;
    if (rd_acc) begin
      case (addr_d)
        `TCOP_CHANPOL_OFF: begin
          rdata_d[CH_N-1:0] = channel_output_polarity_d;
        end
        `TCOP_MODE_OFF: begin
          rdata_d[`TCOP_MODE_PROTDIS_BIT] = write_protect_disable_d;
          rdata_d[`TCOP_MODE_FAULTEN_BIT] = fault_enable_d;
        end
        `TCOP_FLTSTAT_OFF: begin
          rdata_d[`TCOP_FLTSTAT_PROTEN_BIT] = write_protect_enable_d;
        end
        `TCOP_FLTACT_OFF: begin
          rdata_d[`TCOP_FLTACT_BIT] = fault_act;
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // hrdata is launched at the address phase edge and stands for the whole
  // data phase; outside reads it rests at zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= rdata_d;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CH_N; ch = ch + 1) begin : g_pin
      wire normal_lvl;
      wire safe_lvl;
      // an inactive channel rests at its polarity level, the level a fault forces
      assign normal_lvl = chan_active[ch] ^ channel_output_polarity_q[ch];
      assign safe_lvl   = channel_output_polarity_q[ch];
      assign pin_d[ch]  = fault_act ? safe_lvl : normal_lvl;
    end
  endgenerate

  // pins start at the reset polarity with every channel inactive
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_pin <= `TCOP_CHANPOL_RST;
    end else begin
      chan_pin <= pin_d;
    end
  end

endmodule

// *** verilog/tcop_regs.vh ***
// register offsets, field positions and reset values for the channel polarity block
// assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef TCOP_REGS_VH
`define TCOP_REGS_VH
`define TCOP_CHANPOL_OFF        12'h070
`define TCOP_MODE_OFF           12'h054
`define TCOP_FLTSTAT_OFF        12'h074
`define TCOP_FLTACT_OFF         12'h078
`define TCOP_CHANPOL_RST        8'h00
`define TCOP_MODE_PROTDIS_BIT   2
`define TCOP_MODE_FAULTEN_BIT   0
`define TCOP_FLTSTAT_PROTEN_BIT 6
`define TCOP_FLTACT_BIT         0
`define TCOP_NCH                8
`define TCOP_ADDR_W             12
`endif

// *** bench/tcop_polarity_monitor.sv ***
// checker on the polarity block ports
// assumes bind from the bench top
`timescale 1ns/1ps
module tcop_polarity_monitor(input hclk,hresetn,hsel,hreadyout,hresp,fault_in,
  input [1:0] htrans,input [31:0] haddr,hrdata,input [7:0] chan_active,chan_pin);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire q=!fault_in&&!hsel;
  AST_OK: assert property (hreadyout&&!hresp) else $error("bus answer");
  AST_RSV: assert property (hrdata[31:8]==0) else $error("reserved read");
  AST_SNS: assert property (q[*4] |=> chan_pin==($past(chan_pin)^$past(chan_active)^
    $past(chan_active,2))) else $error("pin sense");
  AST_UNM: assert property (hsel&&htrans[1]&&haddr[11:0]==12'h07C |=> hrdata==0)
    else $error("unmapped read");
  wire f=fault_in&&!hsel;
  AST_IDL: assert property (!(hsel&&htrans[1]) |=> hrdata==0) else $error("idle read data");
  AST_FLT: assert property (f[*4] |=> chan_pin==$past(chan_pin)||chan_pin==($past(chan_pin)^
    $past(chan_active)^$past(chan_active,2))) else $error("fault pin level");
  C_F: cover property (fault_in[*4]);
  C_A: cover property (q[*4]);
  C_R: cover property (hsel&&htrans[1]);
endmodule

// *** bench/tcop_load.sv ***
// load model: a channel is energised at its active pin level
`timescale 1ns/1ps
module tcop_load(input [7:0] chan_pin,polarity,output [7:0] on);
  assign on=chan_pin^polarity;
endmodule

// *** bench/test_tcop_polarity.sv ***
// bench for the polarity block; AHB-Lite master and load model
`timescale 1ns/1ps
module test_tcop_polarity;
  reg hclk=0,hresetn=0,hsel=0,hwrite=0,fault_in=0;
  reg [1:0] htrans=0;
  reg [31:0] haddr=0,hwdata=0,r;
  reg [7:0] chan_active=0,polarity=0;
  wire hreadyout,hresp;
  wire [31:0] hrdata;
  wire [7:0] chan_pin,on;
  integer errors=0,samples_checked=0,n;
  always #20 hclk=~hclk;
  tcop_polarity dut(.hclk(hclk),.hresetn(hresetn),.hsel(hsel),.haddr(haddr),.htrans(htrans),
    .hwrite(hwrite),.hsize(3'h2),.hwdata(hwdata),.hready(hreadyout),.hreadyout(hreadyout),
    .hresp(hresp),.hrdata(hrdata),.chan_active(chan_active),.fault_in(fault_in),
    .chan_pin(chan_pin));
  tcop_load load(.chan_pin(chan_pin),.polarity(polarity),.on(on));
  task results; begin $display("errors %0d checks %0d",errors,samples_checked);
    if(errors==0&&samples_checked>0) $display("All checks passed");
    else $display("Checks failed");
    $finish; end endtask
  task ck(input string s,input [31:0] e,g); begin samples_checked++;
    if(g!==e) begin errors++; $display("mismatch %s exp %h got %h",s,e,g); end end endtask
  task wt; begin n=0; @(posedge hclk); while(hreadyout!==1'b1) begin
    if(++n>50) begin errors++; results; end @(posedge hclk); end end endtask
  task xf(input w,input [11:0] a,input [31:0] d); begin
    hsel<=1; htrans<=2'h2; hwrite<=w; haddr<={20'h0,a}; wt;
    hsel<=0; htrans<=2'h0; hwdata<=d; wt; r=hrdata; end endtask
  task t_reset; begin xf(0,12'h070,0); ck("pol",0,r);
    xf(0,12'h074,0); ck("write_protect_enable",32'h40,r&32'h40);
    xf(1,12'h070,32'hFF); xf(0,12'h070,0); ck("lock",0,r); end endtask
  task t_open; begin xf(1,12'h054,32'h4); xf(1,12'h054,32'h5);
    xf(1,12'h070,32'hFFFFFFA5);
    xf(0,12'h070,0); ck("pol",32'hA5,r);
    xf(0,12'h07C,0); ck("unm",0,r);
    xf(0,12'h074,0); ck("write_protect_enable",0,r&32'h40); end endtask
  task t_pins; begin polarity<=8'hA5; chan_active<=8'h3C; repeat(3) @(posedge hclk);
    ck("load",8'h3C,on);
    ck("pin",8'h99,chan_pin);
    fault_in<=1; repeat(4) @(posedge hclk); ck("safe",8'hA5,chan_pin);
    xf(0,12'h078,0); ck("fault",1,r);
    fault_in<=0; repeat(4) @(posedge hclk); end endtask
  task t_rearm; begin xf(1,12'h074,0); xf(1,12'h070,0); xf(0,12'h070,0);
    ck("channel0_polarity_bit",0,r);
    xf(1,12'h074,32'h40); xf(0,12'h074,0); ck("rearmed",32'h40,r&32'h40);
    xf(1,12'h070,32'hFF); xf(0,12'h070,0);
    ck("armed",0,r); end endtask
  initial begin repeat(3) @(posedge hclk); hresetn<=1; @(posedge hclk);
    t_reset; t_open; t_pins; t_rearm; results; end
endmodule
bind tcop_polarity tcop_polarity_monitor mon(.*);
